// ===== rtl/cmc_regs.sv
// connection management control register bank with an AXI4-Lite slave
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module cmc_regs
  import cmc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,

  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,

  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,

  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,

  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,

  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,

  // line state and connection management status
  input  wire logic [2:0]        detected_line_state,
  input  wire logic              unknown_line_state_flag,
  input  wire logic              maintenance_state,

  // datapath multiplexer controls
  output logic                   scrub_mux_en,
  output logic                   bypass_mux_en,
  output logic                   rem_loop_mux_en,

  // connection management fields
  output logic [2:0]             maintenance_line_state,
  output logic [7:0]             pcm_request,

  // interrupt
  output logic                   irq
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------

  // one-hot register select; all zero for an unmapped address
  function automatic logic [CMC_NUM_REGS-1:0] reg_decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [CMC_NUM_REGS-1:0] sel;
    sel = '0;
    if (addr[ADDR_W-1:4] == '0)
      sel[addr[3:2]] = 1'b1;
    return sel;
  endfunction

  // byte-lane merge for the 16-bit registers
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_val,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] res;
    res = old_val;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // local state
  // ----------------------------------------------------------------------

  logic [ADDR_W-1:0]       awaddr_r;
  logic [31:0]             wdata_r;
  logic [3:0]              wstrb_r;
  logic                    wr_fire;
  logic [CMC_NUM_REGS-1:0] wr_sel;
  logic [CMC_NUM_REGS-1:0] rd_sel;

  logic [15:0]             conn_mgmt_r;
  logic [15:0]             dp_ctrl_a_r;
  logic                    event_r;
  logic                    mask_r;
  logic                    match_pulse;
  logic                    event_clr;
  logic                    ctl_enable;
  logic [31:0]             rd_word;

  // ----------------------------------------------------------------------
  // write address and data capture
  // ----------------------------------------------------------------------

  // address and data are held independently, so either may arrive first
  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_sel  = reg_decode(awaddr_r);

  // write address channel: one outstanding write at a time
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      awaddr_r      <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      awaddr_r      <= s_axi_awaddr;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1;
  end

  // write data channel
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_axi_wready <= 1'b1;
      wdata_r      <= '0;
      wstrb_r      <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      wdata_r      <= s_axi_wdata;
      wstrb_r      <= s_axi_wstrb;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // write response
  // ----------------------------------------------------------------------

  // unmapped writes are dropped and flagged with a slave error
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= CMC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (|wr_sel) ? CMC_RESP_OKAY : CMC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // registers written by software
  // ----------------------------------------------------------------------

  // connection_mgmt_control: plain read/write, cleared by reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      conn_mgmt_r <= CMC_CONN_MGMT_RST;
    else if (wr_fire && wr_sel[CMC_IDX_CONN_MGMT])
      conn_mgmt_r <= lane_merge(conn_mgmt_r, wdata_r, wstrb_r);
  end

  // datapath_control_a request bits; they may be written at any time
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      dp_ctrl_a_r <= CMC_DP_CTRL_A_RST;
    else if (wr_fire && wr_sel[CMC_IDX_DP_CTRL_A])
      dp_ctrl_a_r <= lane_merge(dp_ctrl_a_r, wdata_r, wstrb_r);
  end

  // interrupt mask, same layout as the event register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      mask_r <= CMC_MASK_RST;
    else if (wr_fire && wr_sel[CMC_IDX_INT_MASK] && wstrb_r[0])
      mask_r <= wdata_r[CMC_BIT_LINE_STATE_MATCH_EVENT];
  end

  // ----------------------------------------------------------------------
  // line state match event
  // ----------------------------------------------------------------------

  // comparison and edge detection live in their own module
  cmc_line_state_match_event u_line_state_match_event
  (
    .clk_sys                 (clk_sys),
    .rst                     (rst),
    .detected_line_state     (detected_line_state),
    .unknown_line_state_flag (unknown_line_state_flag),
    .line_state_match_select (conn_mgmt_r[CMC_MATCH_LSB +: 4]),
    .match_pulse             (match_pulse)
  );

  // write one to clear
  assign event_clr = wr_fire && wr_sel[CMC_IDX_INT_EVENT] &&
                     wstrb_r[0] && wdata_r[CMC_BIT_LINE_STATE_MATCH_EVENT];

  // sticky; a new match in the clearing cycle still wins
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      event_r <= CMC_EVENT_RST;
    else if (match_pulse)
      event_r <= 1'b1;
    else if (event_clr)
      event_r <= 1'b0;
  end

  // interrupt level follows the event one clock later
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= event_r & mask_r;
  end

  // ----------------------------------------------------------------------
  // datapath multiplexer gating
  // ----------------------------------------------------------------------

  // requests reach the muxes with override set or in maintenance
  assign ctl_enable = conn_mgmt_r[CMC_BIT_OVERRIDE] |
                      maintenance_state;

  // registered so the mux controls never glitch on a state change
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      scrub_mux_en    <= 1'b0;
      bypass_mux_en   <= 1'b0;
      rem_loop_mux_en <= 1'b0;
    end
    else
    begin
      scrub_mux_en    <= dp_ctrl_a_r[CMC_BIT_SCRUB] & ctl_enable;
      bypass_mux_en   <= dp_ctrl_a_r[CMC_BIT_BYPASS] & ctl_enable;
      rem_loop_mux_en <= dp_ctrl_a_r[CMC_BIT_REM_LOOP] & ctl_enable;
    end
  end

  // ----------------------------------------------------------------------
  // connection management fields
  // ----------------------------------------------------------------------

  // taken straight from the register flops
  assign maintenance_line_state = conn_mgmt_r[CMC_MAINTENANCE_STATE_LSB +: 3];
  assign pcm_request            = conn_mgmt_r[CMC_PCM_REQ_LSB +: 8];

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------

  assign rd_sel = reg_decode(s_axi_araddr);

  // read mux; bits above each register's width read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (1'b1)
      rd_sel[CMC_IDX_DP_CTRL_A]: rd_word[15:0] = dp_ctrl_a_r;
      rd_sel[CMC_IDX_CONN_MGMT]: rd_word[15:0] = conn_mgmt_r;
      rd_sel[CMC_IDX_INT_EVENT]: rd_word[CMC_BIT_LINE_STATE_MATCH_EVENT] = event_r;
      rd_sel[CMC_IDX_INT_MASK]:  rd_word[CMC_BIT_LINE_STATE_MATCH_EVENT] = mask_r;
      default:                   rd_word = 32'h0000_0000;
    endcase
  end

  // data is captured at the address handshake; reads have no side effect
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= CMC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= (|rd_sel) ? CMC_RESP_OKAY : CMC_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

endmodule

// ===== rtl/cmc_pkg.sv
// constants for the connection management control register bank
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package cmc_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned CMC_IDX_DP_CTRL_A  = 0;
  localparam int unsigned CMC_IDX_CONN_MGMT  = 1;
  localparam int unsigned CMC_IDX_INT_EVENT  = 2;
  localparam int unsigned CMC_IDX_INT_MASK   = 3;
  localparam int unsigned CMC_NUM_REGS       = 4;

  // connection_mgmt_control field positions
  localparam int unsigned CMC_BIT_OVERRIDE   = 15;
  localparam int unsigned CMC_MATCH_LSB      = 11;
  localparam int unsigned CMC_MAINTENANCE_STATE_LSB      = 8;
  localparam int unsigned CMC_PCM_REQ_LSB    = 0;

  // datapath_control_a request bits
  localparam int unsigned CMC_BIT_REM_LOOP   = 2;
  localparam int unsigned CMC_BIT_BYPASS     = 3;
  localparam int unsigned CMC_BIT_SCRUB      = 4;

  // line_state_match_select bit per line state
  localparam int unsigned CMC_SEL_QUIET      = 3;
  localparam int unsigned CMC_SEL_MASTER     = 2;
  localparam int unsigned CMC_SEL_HALT       = 1;
  localparam int unsigned CMC_SEL_IDLE       = 0;

  // interrupt_event_register bit
  localparam int unsigned CMC_BIT_LINE_STATE_MATCH_EVENT   = 0;

  // values after reset
  localparam logic [15:0] CMC_CONN_MGMT_RST  = 16'h0000;
  localparam logic [15:0] CMC_DP_CTRL_A_RST  = 16'h0000;
  localparam logic        CMC_EVENT_RST      = 1'h0;
  localparam logic        CMC_MASK_RST       = 1'h0;

  // detected_line_state codes
  localparam logic [2:0]  CMC_LS_QUIET       = 3'h0;
  localparam logic [2:0]  CMC_LS_MASTER      = 3'h1;
  localparam logic [2:0]  CMC_LS_HALT        = 3'h2;
  localparam logic [2:0]  CMC_LS_IDLE        = 3'h3;
  localparam logic [2:0]  CMC_LS_ACTIVE      = 3'h4;

  // maintenance_line_state source codes
  localparam logic [2:0]  CMC_MAINTENANCE_STATE_QUIET    = 3'h0;
  localparam logic [2:0]  CMC_MAINTENANCE_STATE_IDLE     = 3'h1;
  localparam logic [2:0]  CMC_MAINTENANCE_STATE_HALT     = 3'h2;

  // idle symbols needed before idle counts as detected
  localparam int unsigned CMC_ILS_SYMBOLS    = 16;

  // bus responses
  localparam logic [1:0]  CMC_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  CMC_RESP_SLVERR    = 2'h2;

endpackage

// ===== rtl/cmc_line_state_match_event.sv
// line state match detector feeding the match interrupt event
`timescale 1ns/1ps
module cmc_line_state_match_event
  import cmc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // line state from the detector
  input  wire logic [2:0] detected_line_state,
  input  wire logic       unknown_line_state_flag,
  // selection from the control register
  input  wire logic [3:0] line_state_match_select,
  // one-cycle event
  output logic            match_pulse
);

  localparam int CNT_W = $clog2(CMC_ILS_SYMBOLS + 1);
  localparam logic [CNT_W-1:0] ILS_FULL = CNT_W'(CMC_ILS_SYMBOLS);

  logic [CNT_W-1:0] idle_cnt_r;
  logic             idle_sixteen_symbols;
  logic [3:0]       state_hit;
  logic             hit_now;
  logic             hit_r;
  logic [2:0]       prev_ls_r;
  logic             prev_unk_r;
  logic             primed_r;
  logic             changed;

  // one symbol per clock; saturate once sixteen are seen
  always_ff @(posedge clk_sys)
  begin
    if (rst || detected_line_state != CMC_LS_IDLE)
      idle_cnt_r <= '0;
    else if (idle_cnt_r != ILS_FULL)
      idle_cnt_r <= idle_cnt_r + CNT_W'(1);
  end

  assign idle_sixteen_symbols = (idle_cnt_r == ILS_FULL);

  // one select bit each for quiet, master, halt and idle; active has none
  always_comb
  begin
    state_hit = '0;
    state_hit[CMC_SEL_QUIET]  = (detected_line_state == CMC_LS_QUIET);
    state_hit[CMC_SEL_MASTER] = (detected_line_state == CMC_LS_MASTER);
    state_hit[CMC_SEL_HALT]   = (detected_line_state == CMC_LS_HALT);
    state_hit[CMC_SEL_IDLE]   = idle_sixteen_symbols;
  end

  assign hit_now = |(state_hit & line_state_match_select);
  assign changed = primed_r &&
                   (detected_line_state != prev_ls_r ||
                    unknown_line_state_flag != prev_unk_r);

  // history; primed keeps the first cycle after reset from looking like a change
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      hit_r       <= 1'b0;
      prev_ls_r   <= CMC_LS_QUIET;
      prev_unk_r  <= 1'b0;
      primed_r    <= 1'b0;
      match_pulse <= 1'b0;
    end
    else
    begin
      hit_r       <= hit_now;
      prev_ls_r   <= detected_line_state;
      prev_unk_r  <= unknown_line_state_flag;
      primed_r    <= 1'b1;
      if (line_state_match_select == 4'h0)
        match_pulse <= changed;
      else
        match_pulse <= hit_now & ~hit_r;
    end
  end

endmodule

// ===== tb/cmc_regs_asserts.sv
// port checker for the control register bank
`timescale 1ns/1ps
module cmc_regs_chk
  import cmc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // status and outputs
  input wire logic              maintenance_state,
  input wire logic              scrub_mux_en,
  input wire logic              bypass_mux_en,
  input wire logic              rem_loop_mux_en,
  input wire logic [2:0]        maintenance_line_state,
  input wire logic [7:0]        pcm_request,
  input wire logic              irq
);
  logic [ADDR_W-1:0] aw_r;
  logic [31:0]       wd_r;
  logic [3:0]        ws_r;
  logic              bv_r;
  logic              ovr_r;
  logic              bv_rise;
  logic              ctl_upd;
  logic              mux_any;

  // ------------
  // shadow of accepted writes
  // ------------
  assign bv_rise = s_axi_bvalid && !bv_r;
  assign ctl_upd = bv_rise && aw_r[ADDR_W-1:2] == 1 && s_axi_bresp == 2'h0;
  assign mux_any = scrub_mux_en | bypass_mux_en | rem_loop_mux_en;

  // capture each channel on its own handshake
  always_ff @(posedge clk_sys)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_r <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
    begin
      wd_r <= s_axi_wdata;
      ws_r <= s_axi_wstrb;
    end
    bv_r <= s_axi_bvalid;
  end

  // override lags the real bit by one edge, safe for a gate check
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ovr_r <= 1'b0;
    else if (ctl_upd && ws_r[1])
      ovr_r <= wd_r[15];
  end

  // ------------
  // properties
  // ------------
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_RST_CLEAR:
    assert property ($fell(rst) |-> pcm_request == 8'h00 && !irq
      && maintenance_line_state == 3'h0 && !mux_any)
    else $error("outputs not clear after reset");
  AST_WR_ANSWER:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_RD_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_WR_FIELD:
    assert property (ctl_upd && ws_r == 4'hF |->
      maintenance_line_state == wd_r[10:8] && pcm_request == wd_r[7:0])
    else $error("control fields not written");
  AST_UNMAPPED:
    assert property (bv_rise && aw_r[ADDR_W-1:4] != 0 |->
      s_axi_bresp == CMC_RESP_SLVERR)
    else $error("unmapped write not refused");
  AST_MUX_GATE:
    assert property (mux_any |-> ovr_r || $past(maintenance_state)
      || $past(maintenance_state, 2))
    else $error("mux enabled without override or maintenance");
  AST_IRQ_HOLD:
    assert property ($fell(irq) |-> $past(s_axi_bvalid)
      || $past(s_axi_bvalid, 2))
    else $error("interrupt dropped without a write");

  cover property (ctl_upd);
  cover property ($rose(irq));
  cover property ($rose(scrub_mux_en));
endmodule

bind cmc_regs cmc_regs_chk #(.ADDR_W(ADDR_W)) i_cmc_regs_chk (
  .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .maintenance_state,
  .scrub_mux_en, .bypass_mux_en, .rem_loop_mux_en,
  .maintenance_line_state, .pcm_request, .irq);

// ===== tb/tb_connection_mgmt_control_reg.sv
// self-checking bench for the control register bank
`timescale 1ns/1ps
module tb_connection_mgmt_control_reg
  import cmc_pkg::*;
;
  logic        clk_sys, rst, irq, maintenance_state, unknown_line_state_flag;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pcm_request;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [2:0]  detected_line_state, maintenance_line_state;
  logic        scrub_mux_en, bypass_mux_en, rem_loop_mux_en;
  int          bad_count, cmp_count;

  cmc_regs i_cmc_regs (
    .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .detected_line_state, .unknown_line_state_flag,
    .maintenance_state, .scrub_mux_en, .bypass_mux_en, .rem_loop_mux_en,
    .maintenance_line_state, .pcm_request, .irq);

  // 25 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ------------
  // helpers
  // ------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // a hung handshake counts as a mismatch
  task automatic guard(input int n);
    if (n > 50)
    begin
      bad_count++;
      $display("wrong value handshake cycles expected %0d seen %0d", 50, n);
      finish_test();
    end
  endtask

  // handshakes are judged at the falling edge to dodge update races
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic ah, wh, bh;
    logic [1:0] r;
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bh = 1'b0;
    n = 0;
    while (!bh)
    begin
      @(negedge clk_sys);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid & s_axi_bready;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) s_axi_bready <= 1'b0;
      n++;
      guard(n);
    end
    chk("bresp", 32'(er), 32'(r));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rh = 1'b0;
    n = 0;
    while (!rh)
    begin
      @(negedge clk_sys);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) s_axi_rready <= 1'b0;
      n++;
      guard(n);
    end
    chk("rdata", e, d);
    chk("rresp", 32'(er), 32'(r));
  endtask

  task automatic mux(input logic [2:0] e);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("mux", 32'(e), 32'({scrub_mux_en, bypass_mux_en, rem_loop_mux_en}));
    @(posedge clk_sys);
  endtask

  // select, move the line to st, then away again; event must stick
  task automatic match_case(input logic [3:0] sel, input logic [2:0] st,
                            input logic e);
    @(posedge clk_sys);
    detected_line_state <= CMC_LS_ACTIVE;
    wr(8'h04, 32'(sel) << 11, 4'hF, CMC_RESP_OKAY);
    wr(8'h08, 32'h0000_0001, 4'hF, CMC_RESP_OKAY);
    detected_line_state <= st;
    repeat (4) @(posedge clk_sys);
    rd(8'h08, 32'(e), CMC_RESP_OKAY);
    @(negedge clk_sys);
    chk("irq", 32'(e), 32'(irq));
    @(posedge clk_sys);
    detected_line_state <= CMC_LS_ACTIVE;
    repeat (4) @(posedge clk_sys);
    rd(8'h08, 32'(e), CMC_RESP_OKAY);
  endtask

  // ------------
  // scenarios
  // ------------
  task automatic t_regs();
    rd(8'h04, 32'h0000_0000, CMC_RESP_OKAY);
    rd(8'h08, 32'h0000_0000, CMC_RESP_OKAY);
    wr(8'h04, 32'h0000_A5C3, 4'hF, CMC_RESP_OKAY);
    rd(8'h04, 32'h0000_A5C3, CMC_RESP_OKAY);
    chk("pcm", 32'h0000_00C3, 32'(pcm_request));
    wr(8'h04, 32'h0000_1200, 4'h2, CMC_RESP_OKAY);
    wr(8'h40, 32'h0000_FFFF, 4'hF, CMC_RESP_SLVERR);
    rd(8'h40, 32'h0000_0000, CMC_RESP_SLVERR);
    rd(8'h04, 32'h0000_12C3, CMC_RESP_OKAY);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h04, 32'(i) << 8, 4'hF, CMC_RESP_OKAY);
      chk("maintenance_line_state", 32'(i), 32'(maintenance_line_state));
    end
    $display("test done: registers");
  endtask

  task automatic t_mux();
    wr(8'h00, 32'h0000_001C, 4'hF, CMC_RESP_OKAY);
    mux(3'h0);
    wr(8'h04, 32'h0000_8000, 4'hF, CMC_RESP_OKAY);
    mux(3'h7);
    wr(8'h04, 32'h0000_0000, 4'hF, CMC_RESP_OKAY);
    mux(3'h0);
    maintenance_state <= 1'b1;
    mux(3'h7);
    $display("test done: datapath gating");
  endtask

  task automatic t_match();
    wr(8'h0C, 32'h0000_0001, 4'hF, CMC_RESP_OKAY);
    match_case(4'h8, CMC_LS_QUIET, 1'b1);
    match_case(4'h4, CMC_LS_MASTER, 1'b1);
    match_case(4'h2, CMC_LS_HALT, 1'b1);
    // quiet and halt selected: master misses, halt hits
    match_case(4'hA, CMC_LS_MASTER, 1'b0);
    match_case(4'hA, CMC_LS_HALT, 1'b1);
    match_case(4'h0, CMC_LS_HALT, 1'b1);
    wr(8'h08, 32'h0000_0001, 4'hF, CMC_RESP_OKAY);
    unknown_line_state_flag <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(8'h08, 32'h0000_0001, CMC_RESP_OKAY);
    // idle only counts after sixteen idle clocks
    wr(8'h04, 32'h0000_0800, 4'hF, CMC_RESP_OKAY);
    wr(8'h08, 32'h0000_0001, 4'hF, CMC_RESP_OKAY);
    detected_line_state <= CMC_LS_IDLE;
    // read is taken at the 18th idle edge, the same edge at which the event sets
    repeat (16) @(posedge clk_sys);
    rd(8'h08, 32'h0000_0000, CMC_RESP_OKAY);
    repeat (12) @(posedge clk_sys);
    rd(8'h08, 32'h0000_0001, CMC_RESP_OKAY);
    // masking hides the interrupt but keeps the event
    wr(8'h0C, 32'h0000_0000, 4'hF, CMC_RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    rd(8'h08, 32'h0000_0001, CMC_RESP_OKAY);
    $display("test done: line state match");
  endtask

  // ------------
  // main sequence
  // ------------
  initial
  begin
    bad_count = 0;
    cmp_count = 0;
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, maintenance_state} = '0;
    unknown_line_state_flag = 1'b0;
    detected_line_state = CMC_LS_ACTIVE;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_mux();
    t_match();
    finish_test();
  end
endmodule
